// ===== rtl/dbt_pkg.sv
// constants, types and register map of the dual registered bus transceiver
// assumes one core clock; all pins are resynchronised inside the top module
//
// Summary of operation
// - A-side load enable low: A bus captured into A register on A clock rise.
// - A-side load enable high: A register holds, whatever the A clock does.
// - B-side load enable low: B bus captured into B register on B clock rise.
// - B-side load enable high: B register holds, whatever the B clock does.
// - B-side drive enable low: A register content driven onto the B bus; here only while control bit CTRL_B_GATE is set.
// - B-side drive enable high: all B bus lines released to high impedance.
// - A-side drive enable low: B register content driven onto the A bus; here only while control bit CTRL_A_GATE is set.
// - A-side drive enable high: all A bus lines released to high impedance.
// - A bus is eight two-way lines; others drive it only while ours is off.
// - B bus is eight two-way lines; others drive it only while ours is off.
// - two independent eight-bit registers, one per direction, own controls each.
// - build option: enabled outputs true or complemented; disabled stay released.
package dbt_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W   = 8;
   localparam int ADDR_W   = 5;
   localparam int AVS_W    = 32;
   localparam int BUF_DEPTH = 2;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_AREG   = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_BREG   = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_SNOOP  = 5'h10;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_A_GATE = 0;
   localparam int CTRL_B_GATE = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   localparam int ST_A_LOAD_N  = 0;
   localparam int ST_B_LOAD_N  = 1;
   localparam int ST_A_DRIVE_N = 2;
   localparam int ST_B_DRIVE_N = 3;
   localparam int ST_SNOOP_VAL = 4;
   localparam int ST_OVERFLOW  = 5;
   localparam int ST_W         = 6;

   localparam int SNOOP_SIDE_BIT  = 8;
   localparam int SNOOP_VALID_BIT = 9;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } dbt_bus_e;

   // one captured word as seen by the snoop buffer; side 0 = A, 1 = B
   typedef struct packed {
      logic              side;
      logic [DATA_W-1:0] data;
   } dbt_word_s;

   // pin bundle after resynchronisation
   typedef struct packed {
      logic              aClk;
      logic              bClk;
      logic              aLoadN;
      logic              bLoadN;
      logic              aDriveN;
      logic              bDriveN;
      logic [DATA_W-1:0] aBus;
      logic [DATA_W-1:0] bBus;
   } dbt_pins_s;

   localparam dbt_pins_s PINS_IDLE = '{
      aClk: 1'b0, bClk: 1'b0, aLoadN: 1'b1, bLoadN: 1'b1,
      aDriveN: 1'b1, bDriveN: 1'b1, aBus: 8'h00, bBus: 8'h00};

endpackage

// ===== rtl/dbt_skid_buffer.sv
// small valid/ready buffer holding captured words for software
// assumes writer and reader share core_clk; reset synchronous, active high
`timescale 1ns/1ps
module dbt_skid_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("buffer depth must be a power of two of at least two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wrPtr;
   logic [PTR_W-1:0] rdPtr;
   logic [PTR_W:0]   count;

   wire doPush = inValid & inReady;
   wire doPop  = outValid & outReady;

   // honest flags straight from the occupancy count
   assign inReady  = (count != (PTR_W+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) wrPtr <= wrPtr + 1'b1;
         if (doPop) rdPtr <= rdPtr + 1'b1;
         count <= count + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
      end
   end

   // entries carry no reset; only valid ones are ever seen
   always_ff @(posedge core_clk) begin
      if (doPush) mem[wrPtr] <= inData;
   end

endmodule // dbt_skid_buffer

// ===== rtl/dbt_transceiver.sv
// dual registered bus transceiver with an avalon-mm control port
// assumes bus pins arrive asynchronously and are resolved by an outside pad
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dbt_transceiver #(
   parameter int  DATA_W         = dbt_pkg::DATA_W,
   parameter bit  INVERT_OUTPUTS = 1'b0,
   parameter int  BUF_DEPTH      = dbt_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   // a side pins
   input  wire logic                       a_side_capture_clock,
   input  wire logic                       a_side_load_enable_n,
   input  wire logic                       a_side_drive_enable_n,
   input  wire logic [DATA_W-1:0]          aSideBusIn,
   output logic [DATA_W-1:0]               aSideBusOut,
   output logic [DATA_W-1:0]               aSideBusOe,
   // b side pins
   input  wire logic                       b_side_capture_clock,
   input  wire logic                       b_side_load_enable_n,
   input  wire logic                       b_side_drive_enable_n,
   input  wire logic [DATA_W-1:0]          bSideBusIn,
   output logic [DATA_W-1:0]               bSideBusOut,
   output logic [DATA_W-1:0]               bSideBusOe,
   // avalon-mm slave
   input  wire logic [dbt_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [dbt_pkg::AVS_W-1:0]  avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic [dbt_pkg::AVS_W-1:0]       avs_readdata,
   output logic                            avs_waitrequest
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // refused at elaboration: the word type is sized from the package,
   // and a shorter buffer cannot take a word while software is still
   // reading the one before it
   if (DATA_W != dbt_pkg::DATA_W) begin : g_bad_width
      $error("data width must match the package word type");
   end
   if (BUF_DEPTH < 2) begin : g_bad_depth
      $error("snoop buffer needs at least two entries");
   end
   if ((BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_pow2
      $error("snoop buffer depth must be a power of two");
   end

   localparam int AW = dbt_pkg::AVS_W;

   // ---------------------------------------------------------------
   // pin resynchronisation
   // ---------------------------------------------------------------
   // every pin passes two flops; data and strobes share the same
   // latency so a captured word lines up with its clock edge. limit:
   // the pin clock must stay well below core_clk / 4.
   dbt_pkg::dbt_pins_s pinsRaw;
   dbt_pkg::dbt_pins_s syncOne;
   dbt_pkg::dbt_pins_s syncTwo;
   logic               aClkPrev;
   logic               bClkPrev;

   assign pinsRaw = '{
      aClk:    a_side_capture_clock,
      bClk:    b_side_capture_clock,
      aLoadN:  a_side_load_enable_n,
      bLoadN:  b_side_load_enable_n,
      aDriveN: a_side_drive_enable_n,
      bDriveN: b_side_drive_enable_n,
      aBus:    aSideBusIn,
      bBus:    bSideBusIn};

   always_ff @(posedge core_clk) begin
      if (reset) begin
         syncOne <= dbt_pkg::PINS_IDLE;
         syncTwo <= dbt_pkg::PINS_IDLE;
      end else begin
         syncOne <= pinsRaw;
         syncTwo <= syncOne;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         aClkPrev <= 1'b0;
         bClkPrev <= 1'b0;
      end else begin
         aClkPrev <= syncTwo.aClk;
         bClkPrev <= syncTwo.bClk;
      end
   end

   // ---------------------------------------------------------------
   // capture decode
   // ---------------------------------------------------------------
   wire aClkRise = syncTwo.aClk & ~aClkPrev;
   wire bClkRise = syncTwo.bClk & ~bClkPrev;
   wire aLoad    = aClkRise & ~syncTwo.aLoadN;
   wire bLoad    = bClkRise & ~syncTwo.bLoadN;

   // ---------------------------------------------------------------
   // direction registers
   // ---------------------------------------------------------------
   // no reset here on purpose: power-up content is undefined
   logic [DATA_W-1:0] aReg;
   logic [DATA_W-1:0] bReg;

   always_ff @(posedge core_clk) begin
      if (aLoad) aReg <= syncTwo.aBus;
   end

   always_ff @(posedge core_clk) begin
      if (bLoad) bReg <= syncTwo.bBus;
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   logic [1:0] ctrl;

   // ---------------------------------------------------------------
   // output drivers
   // ---------------------------------------------------------------
   wire [DATA_W-1:0] polMask  = INVERT_OUTPUTS ? '1 : '0;
   wire [DATA_W-1:0] next_aOut = bReg ^ polMask;
   wire [DATA_W-1:0] next_bOut = aReg ^ polMask;
   wire aDriveOn = ~syncTwo.aDriveN & ctrl[dbt_pkg::CTRL_A_GATE];
   wire bDriveOn = ~syncTwo.bDriveN & ctrl[dbt_pkg::CTRL_B_GATE];

   // data pass through a flop so the pad sees no decode glitches;
   // enables stay low through reset so the buses start released
   always_ff @(posedge core_clk) begin
      if (reset) begin
         aSideBusOut <= '0;
         bSideBusOut <= '0;
      end else begin
         aSideBusOut <= next_aOut;
         bSideBusOut <= next_bOut;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         aSideBusOe <= '0;
         bSideBusOe <= '0;
      end else begin
         aSideBusOe <= {DATA_W{aDriveOn}};
         bSideBusOe <= {DATA_W{bDriveOn}};
      end
   end

   // the two directions share the core clock, reset and snoop buffer but no drive interlock; a fight on
   // a bus is the outside logic's to avoid

   // ---------------------------------------------------------------
   // snoop buffer of captured words
   // ---------------------------------------------------------------
   // one word per cycle: when both sides load together the b word is
   // dropped and flagged, trading a second write port for area
   dbt_pkg::dbt_word_s pushWord;
   dbt_pkg::dbt_word_s headWord;
   logic               pushReady;
   logic               headValid;
   logic               popReq;

   wire pushValid = aLoad | bLoad;
   dbt_pkg::dbt_word_s aWord;
   dbt_pkg::dbt_word_s bWord;

   assign aWord.side = 1'b0;
   assign aWord.data = syncTwo.aBus;
   assign bWord.side = 1'b1;
   assign bWord.data = syncTwo.bBus;
   // with both loading in one cycle the a word goes in, the b word is lost
   assign pushWord = aLoad ? aWord : bWord;
   wire pushLost  = (pushValid & ~pushReady) | (aLoad & bLoad);

   dbt_skid_buffer #(
      .WIDTH ($bits(dbt_pkg::dbt_word_s)),
      .DEPTH (BUF_DEPTH)
   ) u_snoop (
      .core_clk (core_clk),
      .reset    (reset),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (pushWord),
      .outValid (headValid),
      .outReady (popReq),
      .outData  (headWord)
   );

   // ---------------------------------------------------------------
   // avalon-mm slave
   // ---------------------------------------------------------------
   // every access takes one wait cycle: read data are registered in
   // the first cycle and the access completes in the second
   dbt_pkg::dbt_bus_e busState;
   dbt_pkg::dbt_bus_e next_busState;

   wire reqActive = avs_read | avs_write;
   wire finishing = reqActive & (busState == dbt_pkg::BUS_ANSWER);

   assign avs_waitrequest = reqActive & (busState == dbt_pkg::BUS_IDLE);

   always_comb begin
      case (busState)
         dbt_pkg::BUS_IDLE: begin
            next_busState = reqActive ? dbt_pkg::BUS_ANSWER
                                      : dbt_pkg::BUS_IDLE;
         end
         dbt_pkg::BUS_ANSWER: begin
            next_busState = dbt_pkg::BUS_IDLE;
         end
         default: begin
            next_busState = dbt_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) busState <= dbt_pkg::BUS_IDLE;
      else busState <= next_busState;
   end

   // address decode
   wire hitCtrl   = (avs_address == dbt_pkg::OFF_CTRL);
   wire hitStatus = (avs_address == dbt_pkg::OFF_STATUS);
   wire hitAReg   = (avs_address == dbt_pkg::OFF_AREG);
   wire hitBReg   = (avs_address == dbt_pkg::OFF_BREG);
   wire hitSnoop  = (avs_address == dbt_pkg::OFF_SNOOP);
   wire lowLane   = avs_byteenable[0];
   wire writeCtrl = finishing & avs_write & hitCtrl & lowLane;
   wire writeStat = finishing & avs_write & hitStatus & lowLane;

   // reading the snoop word pops it at the completing edge
   assign popReq = finishing & avs_read & hitSnoop & headValid;

   // ---------------------------------------------------------------
   // control and sticky overflow
   // ---------------------------------------------------------------
   logic overflow;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl <= dbt_pkg::CTRL_RESET;
      end else if (writeCtrl) begin
         ctrl[dbt_pkg::CTRL_A_GATE] <=
            avs_writedata[dbt_pkg::CTRL_A_GATE];
         ctrl[dbt_pkg::CTRL_B_GATE] <=
            avs_writedata[dbt_pkg::CTRL_B_GATE];
      end
   end

   // write one to clear; a loss in the same cycle wins over the clear
   wire clearOvf = writeStat & avs_writedata[dbt_pkg::ST_OVERFLOW];

   always_ff @(posedge core_clk) begin
      if (reset) overflow <= 1'b0;
      else if (pushLost) overflow <= 1'b1;
      else if (clearOvf) overflow <= 1'b0;
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   logic [dbt_pkg::ST_W-1:0] statusWord;

   assign statusWord[dbt_pkg::ST_A_LOAD_N]  = syncTwo.aLoadN;
   assign statusWord[dbt_pkg::ST_B_LOAD_N]  = syncTwo.bLoadN;
   assign statusWord[dbt_pkg::ST_A_DRIVE_N] = syncTwo.aDriveN;
   assign statusWord[dbt_pkg::ST_B_DRIVE_N] = syncTwo.bDriveN;
   assign statusWord[dbt_pkg::ST_SNOOP_VAL] = headValid;
   assign statusWord[dbt_pkg::ST_OVERFLOW]  = overflow;

   wire [AW-1:0] ctrlRead   = {{(AW-2){1'b0}}, ctrl};
   wire [AW-1:0] statusRead = {{(AW-dbt_pkg::ST_W){1'b0}}, statusWord};
   wire [AW-1:0] aRegRead   = {{(AW-DATA_W){1'b0}}, aReg};
   wire [AW-1:0] bRegRead   = {{(AW-DATA_W){1'b0}}, bReg};
   wire [AW-1:0] snoopRead  =
      {{(AW-dbt_pkg::SNOOP_VALID_BIT-1){1'b0}}, headValid,
       headWord.side & headValid,
       headWord.data & {DATA_W{headValid}}};

   // unmapped addresses read as zero and still complete
   wire [AW-1:0] readMux =
      hitCtrl   ? ctrlRead   :
      hitStatus ? statusRead :
      hitAReg   ? aRegRead   :
      hitBReg   ? bRegRead   :
      hitSnoop  ? snoopRead  : '0;

   // read data are taken while waitrequest is still high, so they stand
   // at the edge where the master samples it low
   always_ff @(posedge core_clk) begin
      if (reset) avs_readdata <= '0;
      else if (avs_read & avs_waitrequest) avs_readdata <= readMux;
   end

endmodule // dbt_transceiver

// ===== testbench/dbt_transceiver_assertions.sv
// checks on the transceiver pins, bound into the top module
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module dbt_transceiver_checker #(
   parameter int DATA_W         = 8,
   parameter bit INVERT_OUTPUTS = 1'b0
) (
   // clock and reset
   input wire logic              core_clk,
   input wire logic              reset,
   // a side
   input wire logic              a_side_capture_clock,
   input wire logic              a_side_load_enable_n,
   input wire logic              a_side_drive_enable_n,
   input wire logic [DATA_W-1:0] aSideBusIn,
   input wire logic [DATA_W-1:0] aSideBusOut,
   input wire logic [DATA_W-1:0] aSideBusOe,
   // b side
   input wire logic              b_side_capture_clock,
   input wire logic              b_side_load_enable_n,
   input wire logic              b_side_drive_enable_n,
   input wire logic [DATA_W-1:0] bSideBusIn,
   input wire logic [DATA_W-1:0] bSideBusOut,
   input wire logic [DATA_W-1:0] bSideBusOe
);
   // --------
   // pin edges and the word present at them
   // --------
   logic              aClkQ;
   logic              bClkQ;
   logic [DATA_W-1:0] aSeen;
   logic [DATA_W-1:0] bSeen;
   wire aTake = a_side_capture_clock && !aClkQ && !a_side_load_enable_n;
   wire bTake = b_side_capture_clock && !bClkQ && !b_side_load_enable_n;
   always_ff @(posedge core_clk) begin
      aClkQ <= a_side_capture_clock;
      bClkQ <= b_side_capture_clock;
      if (aTake) aSeen <= aSideBusIn;
      if (bTake) bSeen <= bSideBusIn;
   end
   // --------
   // assertions
   // --------
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // window covers the two-flop pin sync plus register and output stage
   a_flow_a: assert property (
      aTake |=> ##[2:6] bSideBusOut == (INVERT_OUTPUTS ? ~aSeen : aSeen))
      else $error("b bus output missed the captured a word");
   b_flow_a: assert property (
      bTake |=> ##[2:6] aSideBusOut == (INVERT_OUTPUTS ? ~bSeen : bSeen))
      else $error("a bus output missed the captured b word");
   a_hold_a: assert property (
      a_side_load_enable_n [*8] ##0 bSideBusOe[0] |-> $stable(bSideBusOut))
      else $error("a register changed with its load enable off");
   b_hold_a: assert property (
      b_side_load_enable_n [*8] ##0 aSideBusOe[0] |-> $stable(aSideBusOut))
      else $error("b register changed with its load enable off");
   b_release_a: assert property (
      b_side_drive_enable_n [*4] |-> bSideBusOe == '0)
      else $error("b bus still driven after its enable went high");
   a_release_a: assert property (
      a_side_drive_enable_n [*4] |-> aSideBusOe == '0)
      else $error("a bus still driven after its enable went high");
   a_drive_on_a: assert property (
      $rose(aSideBusOe[0]) |-> !$past(a_side_drive_enable_n, 2))
      else $error("a bus driven without its enable low");
   b_drive_on_a: assert property (
      $rose(bSideBusOe[0]) |-> !$past(b_side_drive_enable_n, 2))
      else $error("b bus driven without its enable low");
   uniform_oe_a: assert property (
      aSideBusOe inside {'0, '1} && bSideBusOe inside {'0, '1})
      else $error("bus lines enabled one by one");
   reset_quiet_a: assert property (
      $fell(reset) |-> (aSideBusOe | bSideBusOe) == '0)
      else $error("bus driven straight out of reset");
endmodule // dbt_transceiver_checker

bind dbt_transceiver dbt_transceiver_checker #(
   .DATA_W(DATA_W), .INVERT_OUTPUTS(INVERT_OUTPUTS)) i_chk (
   .core_clk(core_clk), .reset(reset),
   .a_side_capture_clock(a_side_capture_clock),
   .a_side_load_enable_n(a_side_load_enable_n),
   .a_side_drive_enable_n(a_side_drive_enable_n),
   .aSideBusIn(aSideBusIn), .aSideBusOut(aSideBusOut),
   .aSideBusOe(aSideBusOe),
   .b_side_capture_clock(b_side_capture_clock),
   .b_side_load_enable_n(b_side_load_enable_n),
   .b_side_drive_enable_n(b_side_drive_enable_n),
   .bSideBusIn(bSideBusIn), .bSideBusOut(bSideBusOut),
   .bSideBusOe(bSideBusOe));

// ===== testbench/dbt_bus_partner.sv
// far-side logic on both buses: drives a word or leaves the lines open
// assumes index 0 is the a bus and index 1 the b bus
`timescale 1ns/1ps
module dbt_bus_partner (
   // clock
   input wire logic       core_clk,
   // far-side requests
   input wire logic [1:0] drive,
   input wire logic [7:0] value [2],
   // device pins
   input wire logic [7:0] devOut [2],
   input wire logic [7:0] devOe [2],
   // resolved lines
   output logic [7:0]     busLine [2]
);
   logic [7:0] drift [2] = '{8'hA5, 8'h3C};
   // open lines change every cycle so a stale word never passes
   always_ff @(posedge core_clk) begin
      drift[0] <= ~busLine[0];
      drift[1] <= ~busLine[1];
   end
   // far side drives only while the device lines are off
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         busLine[s] = devOe[s] & devOut[s] | ~devOe[s]
            & ((drive[s] && devOe[s] == 8'h00) ? value[s] : drift[s]);
      end
   end
endmodule // dbt_bus_partner

// ===== testbench/tb_top.sv
// bench: pin loads, drive paths, capture buffer and register reads
// assumes the partner model resolves both buses
`timescale 1ns/1ps
module tb_top;
   // --------
   // stimulus and wiring
   // --------
   logic        core_clk = 1'b0;
   logic        reset    = 1'b1;
   logic [1:0]  pinClk   = 2'h0;
   logic [1:0]  loadN    = 2'h3;
   logic [1:0]  driveN   = 2'h3;
   logic [1:0]  farDrive = 2'h0;
   logic [7:0]  farValue [2] = '{8'h00, 8'h00};
   logic [4:0]  address  = 5'h00;
   logic        read     = 1'b0;
   logic        write    = 1'b0;
   logic [31:0] wdata    = 32'h0;
   wire  [7:0]  busWire [2];
   wire  [7:0]  busOut [2];
   wire  [7:0]  busOe [2];
   wire  [7:0]  invOut [2];
   wire  [31:0] rdata;
   wire         waitreq;
   logic [31:0] expQ [$];
   logic [7:0]  held [2];
   logic [7:0]  w [3];
   int          err_count = 0;
   int          n_checks  = 0;
   int          cycles    = 0;
   always #10 core_clk = ~core_clk;
   dbt_transceiver i_dut (
      .core_clk(core_clk), .reset(reset),
      .a_side_capture_clock(pinClk[0]), .a_side_load_enable_n(loadN[0]),
      .a_side_drive_enable_n(driveN[0]), .aSideBusIn(busWire[0]),
      .aSideBusOut(busOut[0]), .aSideBusOe(busOe[0]),
      .b_side_capture_clock(pinClk[1]), .b_side_load_enable_n(loadN[1]),
      .b_side_drive_enable_n(driveN[1]), .bSideBusIn(busWire[1]),
      .bSideBusOut(busOut[1]), .bSideBusOe(busOe[1]),
      .avs_address(address), .avs_read(read), .avs_write(write),
      .avs_writedata(wdata), .avs_byteenable(4'hF),
      .avs_readdata(rdata), .avs_waitrequest(waitreq));
   // complemented copy: its pins only listen to the resolved buses
   dbt_transceiver #(.INVERT_OUTPUTS(1'b1)) i_dut_inv (
      .core_clk(core_clk), .reset(reset),
      .a_side_capture_clock(pinClk[0]), .a_side_load_enable_n(loadN[0]),
      .a_side_drive_enable_n(driveN[0]), .aSideBusIn(busWire[0]),
      .aSideBusOut(invOut[0]), .aSideBusOe(),
      .b_side_capture_clock(pinClk[1]), .b_side_load_enable_n(loadN[1]),
      .b_side_drive_enable_n(driveN[1]), .bSideBusIn(busWire[1]),
      .bSideBusOut(invOut[1]), .bSideBusOe(),
      .avs_address(address), .avs_read(read), .avs_write(write),
      .avs_writedata(wdata), .avs_byteenable(4'hF),
      .avs_readdata(), .avs_waitrequest());
   dbt_bus_partner i_far (.core_clk(core_clk), .drive(farDrive),
      .value(farValue), .devOut(busOut), .devOe(busOe), .busLine(busWire));
   // --------
   // tasks
   // --------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // request held until waitrequest is sampled low, then one idle cycle
   task automatic access(input logic wr, input logic [4:0] adr,
                         input logic [31:0] d);
      int n;
      n = 0;
      address <= adr;
      wdata   <= d;
      read    <= !wr;
      write   <= wr;
      @(posedge core_clk);
      while (waitreq !== 1'b0 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [4:0] adr, input logic [31:0] exp);
      expQ.push_back(exp);
      access(1'b0, adr, 32'h0);
   endtask
   // word and enable stand three core cycles each side of the pin edge
   task automatic load(input int s, input logic [7:0] d, input logic en_n);
      farValue[s] <= d;
      farDrive[s] <= 1'b1;
      loadN[s]    <= en_n;
      repeat (3) @(posedge core_clk);
      pinClk[s] <= 1'b1;
      repeat (3) @(posedge core_clk);
      pinClk[s]   <= 1'b0;
      farDrive[s] <= 1'b0;
      loadN[s]    <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask
   // --------
   // read monitor and timeout
   // --------
   always @(posedge core_clk) begin
      cycles++;
      if (read && waitreq === 1'b0 && expQ.size() > 0) begin
         check(rdata, expQ.pop_front());
      end
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end
   // --------
   // scenarios
   // --------
   initial begin
      int s;
      logic [4:0] adr;
      void'($urandom(32'h2470));
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(dbt_pkg::OFF_CTRL, 32'h3);
      rd(dbt_pkg::OFF_STATUS, 32'hF);
      rd(5'h14, 32'h0);
      check({busOe[0], busOe[1]}, 16'h0);
      for (s = 0; s < 2; s++) begin
         adr = s ? dbt_pkg::OFF_BREG : dbt_pkg::OFF_AREG;
         held[s] = 8'($urandom);
         load(s, held[s], 1'b0);
         rd(adr, {24'h0, held[s]});
         load(s, ~held[s], 1'b1);
         rd(adr, {24'h0, held[s]});
      end
      rd(dbt_pkg::OFF_STATUS, 32'h1F);
      rd(dbt_pkg::OFF_SNOOP, {22'h0, 2'b10, held[0]});
      rd(dbt_pkg::OFF_SNOOP, {22'h0, 2'b11, held[1]});
      rd(dbt_pkg::OFF_STATUS, 32'hF);
      // fill the buffer past its two places, nobody draining
      for (s = 0; s < 3; s++) begin
         w[s] = 8'($urandom);
         load(0, w[s], 1'b0);
      end
      rd(dbt_pkg::OFF_STATUS, 32'h3F);
      rd(dbt_pkg::OFF_AREG, {24'h0, w[2]});
      access(1'b1, dbt_pkg::OFF_STATUS, 32'h20);
      rd(dbt_pkg::OFF_STATUS, 32'h1F);
      for (s = 0; s < 2; s++) begin
         rd(dbt_pkg::OFF_SNOOP, {22'h0, 2'b10, w[s]});
      end
      rd(dbt_pkg::OFF_STATUS, 32'hF);
      held[0] = w[2];
      // both directions driving at once
      driveN <= 2'h0;
      repeat (6) @(posedge core_clk);
      // pin clock edges with loads held off leave both registers alone
      for (s = 0; s < 2; s++) begin
         load(s, 8'($urandom), 1'b1);
      end
      for (s = 0; s < 2; s++) begin
         check({busOe[s], busOut[s]}, {8'hFF, held[1-s]});
         check(invOut[s], 8'(~held[1-s]));
         check(busWire[s], held[1-s]);
      end
      access(1'b1, dbt_pkg::OFF_CTRL, 32'h2);
      repeat (3) @(posedge core_clk);
      check({busOe[0], busOe[1]}, 16'h00FF);
      access(1'b1, dbt_pkg::OFF_CTRL, 32'h3);
      driveN <= 2'h3;
      repeat (4) @(posedge core_clk);
      check({busOe[0], busOe[1]}, 16'h0);
      rd(dbt_pkg::OFF_CTRL, 32'h3);
      stop_test();
   end
endmodule // tb_top
